// File: hw/nrcs_defs.svh
// Purpose: Constants for the NAND cache read sequencer
// Assumes: 125 MHz core clock, one logical unit with two planes
// Notes:   Busy times are plain defaults; adjust them to the array in use
// Notes on behaviour
// - Sequential cache read prefetches next page
// - Cache commands accepted idle or in cache phase
// - Cache command drives busy, clears both bits
// - After busy: pin high, unit ready only
// - Output restarts at column zero
// - Sequential read crosses into next block
// - Random cache read loads addressed page
// - Cache-end copies data, then fully ready
// - Queue command adds plane to pending set
// - Queue command ignores column address
// - Queue busy accepts only status and reset
// - After queue only queue or page read
// - Page read fills queued planes, even first
// - Select cache and change column redirect output
// - Multi-plane sequential steps every plane
`ifndef NRCS_DEFS_SVH
`define NRCS_DEFS_SVH

// ----------------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------------
`define NRCS_CMD_READ      8'h00
`define NRCS_CMD_COLCHG    8'h05
`define NRCS_CMD_SELCACHE  8'h06
`define NRCS_CMD_PAGE      8'h30
`define NRCS_CMD_CACHE     8'h31
`define NRCS_CMD_QUEUE     8'h32
`define NRCS_CMD_LAST      8'h3f
`define NRCS_CMD_STATUS    8'h70
`define NRCS_CMD_STATUS_U  8'h78
`define NRCS_CMD_CONFIRM   8'he0
`define NRCS_CMD_RESET     8'hff
`define NRCS_CMD_RESET_S   8'hfc

// ----------------------------------------------------------------------
// Address layout in the 40-bit capture buffer
// ----------------------------------------------------------------------
`define NRCS_ADDR_CYC      3'h5
`define NRCS_COL_CYC       3'h2
`define NRCS_COL_MSB       12
`define NRCS_PAGE_LSB      16
`define NRCS_PAGE_MSB      22
`define NRCS_PLANE_BIT     23
`define NRCS_BLOCK_LSB     24
`define NRCS_BLOCK_MSB     33
`define NRCS_PAGE_LAST     7'h7f

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define NRCS_CLK_MHZ       125
`define NRCS_RCBSY_NS      3000
`define NRCS_DBSY_NS       500
`define NRCS_ARRAY_NS      20000
`define NRCS_RCBSY_CYC     ((`NRCS_RCBSY_NS * `NRCS_CLK_MHZ + 999) / 1000)
`define NRCS_DBSY_CYC      ((`NRCS_DBSY_NS * `NRCS_CLK_MHZ + 999) / 1000)
`define NRCS_ARRAY_CYC     ((`NRCS_ARRAY_NS * `NRCS_CLK_MHZ + 999) / 1000)

`endif

// File: hw/nrcs_pkg.sv
// Purpose: Types shared by the NAND cache read sequencer
// Assumes: Nothing beyond the defs header
// Notes:   One-hot codes are written out on purpose
package nrcs_pkg;

  // ----------------------------------------------------------------------
  // Unit phase
  // ----------------------------------------------------------------------
  typedef enum logic [5:0] {
    NRCS_ST_IDLE  = 6'h01, // Fully ready
    NRCS_ST_RCBSY = 6'h02, // Cache read busy
    NRCS_ST_CACHE = 6'h04, // Cache phase, array still working
    NRCS_ST_DBSY  = 6'h08, // Plane queue busy
    NRCS_ST_MPQ   = 6'h10, // Planes queued, ready
    NRCS_ST_RBSY  = 6'h20  // Array to cache page read
  } nrcs_state_t;

  // ----------------------------------------------------------------------
  // Open command prefix awaiting address cycles
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    NRCS_PD_NONE = 4'h1,
    NRCS_PD_READ = 4'h2,
    NRCS_PD_COL  = 4'h4,
    NRCS_PD_SEL  = 4'h8
  } nrcs_pend_t;

endpackage

// File: hw/nrcs_page_step.sv
// Purpose: Next page address within one plane
// Assumes: Block index counts blocks inside the plane
// Notes:   Host keeps the walk inside the unit
`timescale 1ns/10ps
`include "nrcs_defs.svh"
module nrcs_page_step (
  input  wire logic [9:0] block,      // Current block in plane
  input  wire logic [6:0] page,       // Current page
  output logic      [9:0] next_block, // Block after stepping
  output logic      [6:0] next_page   // Page after stepping
);

  // ----------------------------------------------------------------------
  // Step
  // ----------------------------------------------------------------------
  // Past the last page, wrap to page zero of the next block
  always_comb begin
    if (page == `NRCS_PAGE_LAST) begin
      next_page  = 7'h00;
      next_block = block + 10'h001;
    end else begin
      next_page  = page + 7'h01;
      next_block = block;
    end
  end

endmodule

// File: hw/nrcs_sequencer.sv
// Purpose: Cache read and multi-plane queue sequencing for one logical unit
// Assumes: Command and address strobes come from the bus front end on clk
// Notes:   Array transfer is timed here; fetch and load pulses steer storage
`timescale 1ns/10ps
`include "nrcs_defs.svh"
module nrcs_sequencer (
  input  wire logic                 clk,             // 125 MHz clock
  input  wire logic                 rst,             // Sync reset, high
  input  wire logic                 ce,              // Clock enable
  input  wire logic                 cmd_we,          // Command byte strobe
  input  wire logic [7:0]           cmd_byte,        // Command byte
  input  wire logic                 addr_we,         // Address byte strobe
  input  wire logic [7:0]           addr_byte,       // Address byte
  input  wire logic                 rd_strobe,       // Host read of one byte
  output logic                      rb_out,          // Ready/busy pin level
  output logic                      rb_oe,           // Ready/busy pulled low
  output logic                      unit_ready,      // Unit ready status bit
  output logic                      array_ready_bit, // Array ready status bit
  output logic                      out_plane,       // Plane feeding output
  output logic [12:0]               rd_col,          // Output column
  output logic                      fetch_go,        // Start array read
  output logic                      fetch_dest,      // 1: to cache, 0: to data
  output logic [1:0]                fetch_mask,      // Planes being read
  output logic [19:0]               fetch_block,     // Block per plane
  output logic [13:0]               fetch_page,      // Page per plane
  output logic                      cache_load,      // Data to cache copy
  output nrcs_pkg::nrcs_state_t     seq_state        // Current phase
);
  import nrcs_pkg::*;

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  nrcs_state_t st;          // Phase
  nrcs_state_t next_st;     // Phase next cycle
  nrcs_pend_t  pend;        // Open prefix
  logic [39:0] abuf;        // Captured address cycles
  logic [2:0]  acnt;        // Address cycles seen
  logic [11:0] bcnt;        // Busy timer
  logic [11:0] fcnt;        // Array transfer timer
  logic [1:0]  active;      // Planes in the cache walk
  logic [1:0]  queued;      // Planes awaiting page read
  logic        job_last;    // Busy ends the sequence
  logic        job_load;    // Busy exit copies data to cache
  logic        job_fetch;   // Busy exit starts next fetch
  logic [19:0] nxt_block;   // Stepped blocks
  logic [13:0] nxt_page;    // Stepped pages
  logic        is_rst;      // Reset command
  logic        pre_ok;      // Five address cycles after 00h
  logic        rdy_st;      // Idle phase
  logic        cac_st;      // Cache phase
  logic        acc_seq;     // Accepted sequential cache read
  logic        acc_rnd;     // Accepted random cache read
  logic        acc_last;    // Accepted cache end
  logic        acc_q;       // Accepted plane queue
  logic        acc_pg;      // Accepted final page read
  logic        acc_col;     // Accepted column change
  logic        acc_sel;     // Accepted cache select
  logic        acc_pre;     // Accepted prefix
  logic        rc_done;     // Cache busy can end
  logic        a_plane;     // Addressed plane
  logic [9:0]  a_block;     // Addressed block
  logic [6:0]  a_page;      // Addressed page
  logic [12:0] a_col;       // Addressed column

  assign a_plane   = abuf[`NRCS_PLANE_BIT];
  assign a_block   = abuf[`NRCS_BLOCK_MSB:`NRCS_BLOCK_LSB];
  assign a_page    = abuf[`NRCS_PAGE_MSB:`NRCS_PAGE_LSB];
  assign a_col     = abuf[`NRCS_COL_MSB:0];
  assign seq_state = st;

  // ----------------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------------
  // others ignored: anything not listed for the phase falls through
  always_comb begin
    rdy_st   = (st == NRCS_ST_IDLE);
    cac_st   = (st == NRCS_ST_CACHE);
    pre_ok   = (pend == NRCS_PD_READ) && (acnt == `NRCS_ADDR_CYC);
    is_rst   = cmd_we && (cmd_byte == `NRCS_CMD_RESET || cmd_byte == `NRCS_CMD_RESET_S);
    acc_seq  = cmd_we && cmd_byte == `NRCS_CMD_CACHE && (rdy_st || cac_st)
               && (pend == NRCS_PD_NONE || (pend == NRCS_PD_READ && acnt == 3'h0));
    acc_rnd  = cmd_we && cmd_byte == `NRCS_CMD_CACHE && pre_ok && (rdy_st || cac_st);
    acc_last = cmd_we && cmd_byte == `NRCS_CMD_LAST && (rdy_st || cac_st);
    acc_q    = cmd_we && cmd_byte == `NRCS_CMD_QUEUE && pre_ok && (rdy_st || st == NRCS_ST_MPQ);
    acc_pg   = cmd_we && cmd_byte == `NRCS_CMD_PAGE && pre_ok && (rdy_st || st == NRCS_ST_MPQ);
    acc_col  = cmd_we && cmd_byte == `NRCS_CMD_CONFIRM && pend == NRCS_PD_COL
               && acnt == `NRCS_COL_CYC && (rdy_st || cac_st);
    acc_sel  = cmd_we && cmd_byte == `NRCS_CMD_CONFIRM && pend == NRCS_PD_SEL
               && acnt == `NRCS_ADDR_CYC && (rdy_st || cac_st);
    acc_pre  = cmd_we && ((cmd_byte == `NRCS_CMD_READ && (rdy_st || cac_st || st == NRCS_ST_MPQ))
               || ((cmd_byte == `NRCS_CMD_COLCHG || cmd_byte == `NRCS_CMD_SELCACHE) && (rdy_st || cac_st)));
    rc_done  = (st == NRCS_ST_RCBSY) && bcnt == 12'h000 && fcnt == 12'h000;
  end

  // ----------------------------------------------------------------------
  // Prefix and address capture
  // ----------------------------------------------------------------------
  // Any other command closes an open prefix, so stray bytes cannot pair up
  always_ff @(posedge clk) begin
    if (rst) begin
      pend <= NRCS_PD_NONE;
      acnt <= 3'h0;
      abuf <= 40'h00_0000_0000;
    end else if (ce) begin
      if (cmd_we) begin
        acnt <= 3'h0;
        if (acc_pre && cmd_byte == `NRCS_CMD_READ) begin
          pend <= NRCS_PD_READ;
        end else if (acc_pre && cmd_byte == `NRCS_CMD_COLCHG) begin
          pend <= NRCS_PD_COL;
        end else if (acc_pre) begin
          pend <= NRCS_PD_SEL;
        end else begin
          pend <= NRCS_PD_NONE;
        end
      end else if (addr_we && pend != NRCS_PD_NONE && acnt < `NRCS_ADDR_CYC) begin
        abuf[{acnt, 3'b000} +: 8] <= addr_byte;
        acnt <= acnt + 3'h1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Phase sequencing
  // ----------------------------------------------------------------------
  always_comb begin
    next_st = st;
    if (is_rst) begin
      next_st = NRCS_ST_IDLE;
    end else begin
      unique case (st)
        NRCS_ST_IDLE, NRCS_ST_CACHE, NRCS_ST_MPQ: begin
          if (acc_seq || acc_rnd || acc_last) begin
            next_st = NRCS_ST_RCBSY;
          end else if (acc_q) begin
            next_st = NRCS_ST_DBSY;
          end else if (acc_pg) begin
            next_st = NRCS_ST_RBSY;
          end
        end
        NRCS_ST_RCBSY: begin
          if (rc_done) begin
            next_st = job_last ? NRCS_ST_IDLE : NRCS_ST_CACHE;
          end
        end
        NRCS_ST_DBSY: begin
          if (bcnt == 12'h000) begin
            next_st = NRCS_ST_MPQ;
          end
        end
        NRCS_ST_RBSY: begin
          if (fcnt == 12'h000) begin
            next_st = NRCS_ST_IDLE;
          end
        end
      endcase
    end
  end

  // Phase register and busy timer
  always_ff @(posedge clk) begin
    if (rst) begin
      st   <= NRCS_ST_IDLE;
      bcnt <= 12'h000;
    end else if (ce) begin
      st <= next_st;
      if (next_st == NRCS_ST_RCBSY && st != NRCS_ST_RCBSY) begin
        bcnt <= 12'(`NRCS_RCBSY_CYC - 1);
      end else if (next_st == NRCS_ST_DBSY && st != NRCS_ST_DBSY) begin
        bcnt <= 12'(`NRCS_DBSY_CYC - 1);
      end else if (bcnt != 12'h000) begin
        bcnt <= bcnt - 12'h001;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Status bits and ready/busy pin
  // ----------------------------------------------------------------------
  // Taken from the next phase so the pin moves with the phase, not after it
  always_ff @(posedge clk) begin
    if (rst) begin
      rb_out          <= 1'b0;
      rb_oe           <= 1'b0;
      unit_ready      <= 1'b1;
      array_ready_bit <= 1'b1;
    end else if (ce) begin
      rb_out          <= 1'b0;
      rb_oe           <= (next_st == NRCS_ST_RCBSY) || (next_st == NRCS_ST_DBSY) || (next_st == NRCS_ST_RBSY);
      unit_ready      <= (next_st == NRCS_ST_IDLE) || (next_st == NRCS_ST_MPQ) || (next_st == NRCS_ST_CACHE);
      array_ready_bit <= (next_st == NRCS_ST_IDLE) || (next_st == NRCS_ST_MPQ);
    end
  end

  // ----------------------------------------------------------------------
  // Array jobs
  // ----------------------------------------------------------------------
  // A new cache command waits for the running fetch, since the data
  // register must be whole before it is copied
  always_ff @(posedge clk) begin
    if (rst || (ce && is_rst)) begin
      job_last   <= 1'b0;
      job_load   <= 1'b0;
      job_fetch  <= 1'b0;
      fetch_go   <= 1'b0;
      fetch_dest <= 1'b0;
      fetch_mask <= 2'b00;
      cache_load <= 1'b0;
      fcnt       <= 12'h000;
    end else if (ce) begin
      fetch_go   <= 1'b0;
      cache_load <= 1'b0;
      if (fcnt != 12'h000) begin
        fcnt <= fcnt - 12'h001;
      end
      if (acc_seq || acc_rnd || acc_last) begin
        job_last  <= acc_last;
        job_load  <= cac_st || acc_last;
        job_fetch <= !acc_last;
      end else if (rc_done) begin
        cache_load <= job_load;
        fetch_go   <= job_fetch;
        fetch_dest <= 1'b0;
        fetch_mask <= active;
        fcnt       <= job_fetch ? 12'(`NRCS_ARRAY_CYC) : 12'h000;
      end else if (acc_pg) begin
        fetch_go   <= 1'b1;
        fetch_dest <= 1'b1;
        fetch_mask <= queued | (a_plane ? 2'b10 : 2'b01);
        fcnt       <= 12'(`NRCS_ARRAY_CYC);
      end
    end
  end

  // ----------------------------------------------------------------------
  // Per-plane page pointers
  // ----------------------------------------------------------------------
  genvar p;
  generate
    for (p = 0; p < 2; p++) begin : g_plane
      nrcs_page_step u_step (
        .block      (fetch_block[p*10 +: 10]),
        .page       (fetch_page[p*7 +: 7]),
        .next_block (nxt_block[p*10 +: 10]),
        .next_page  (nxt_page[p*7 +: 7])
      );

      // Pointer, walk membership and queue bit of one plane
      always_ff @(posedge clk) begin
        if (rst || (ce && is_rst)) begin
          fetch_block[p*10 +: 10] <= 10'h000;
          fetch_page[p*7 +: 7]    <= 7'h00;
          active[p]               <= 1'b0;
          queued[p]               <= 1'b0;
        end else if (ce) begin
          if (acc_seq && active[p]) begin
            fetch_block[p*10 +: 10] <= nxt_block[p*10 +: 10];
            fetch_page[p*7 +: 7]    <= nxt_page[p*7 +: 7];
          end else if ((acc_rnd || acc_pg || acc_q) && a_plane == p[0]) begin
            fetch_block[p*10 +: 10] <= a_block;
            fetch_page[p*7 +: 7]    <= a_page;
          end
          if (acc_rnd || acc_pg) begin
            active[p] <= queued[p] || (a_plane == p[0]);
            queued[p] <= 1'b0;
          end else if (acc_q && a_plane == p[0]) begin
            queued[p] <= 1'b1;
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Output column and plane
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst || (ce && is_rst)) begin
      rd_col    <= 13'h0000;
      out_plane <= 1'b0;
    end else if (ce) begin
      if (acc_seq || acc_rnd || acc_last) begin
        rd_col <= 13'h0000;
      end else if (acc_col) begin
        rd_col <= a_col;
      end else if (acc_sel) begin
        rd_col    <= a_col;
        out_plane <= a_plane;
      end else if (acc_pg) begin
        rd_col    <= a_col;
        out_plane <= (|queued) ? 1'b0 : a_plane;
      end else if (rd_strobe && unit_ready && !acc_q) begin
        rd_col <= rd_col + 13'h0001;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst || !ce);

  AST_CACHE_CMD_BUSY: assert property ((acc_seq || acc_rnd || acc_last) && !is_rst |=>
    rb_oe && !unit_ready && !array_ready_bit) else $error("cache command did not go busy");
  AST_ACCEPT_IN_CACHE: assert property (cac_st && acc_seq |=> st == NRCS_ST_RCBSY)
    else $error("cache command refused in cache phase");
  AST_CACHE_PHASE: assert property (rc_done && !job_last && !is_rst |=>
    !rb_oe && unit_ready && !array_ready_bit) else $error("wrong bits after cache busy");
  AST_COL_ZERO: assert property (acc_seq |=> rd_col == 13'h0000)
    else $error("column not zero after cache read");
  AST_SEQ_STEP: assert property (acc_seq && active[0] && fetch_page[6:0] != `NRCS_PAGE_LAST |=>
    fetch_page[6:0] == $past(fetch_page[6:0]) + 7'h01) else $error("page did not advance");
  AST_BLOCK_CROSS: assert property (acc_seq && active[0] && fetch_page[6:0] == `NRCS_PAGE_LAST |=>
    fetch_page[6:0] == 7'h00 && fetch_block[9:0] == $past(fetch_block[9:0]) + 10'h001)
    else $error("block boundary not crossed");
  AST_RND_LOAD: assert property (acc_rnd && a_plane |=> fetch_page[13:7] == $past(a_page))
    else $error("random page not loaded");
  AST_LAST_READY: assert property (rc_done && job_last |=> unit_ready && array_ready_bit && !rb_oe)
    else $error("cache end not fully ready");
  AST_QUEUE_ADD: assert property (acc_q && a_plane |=> queued[1])
    else $error("plane not queued");
  AST_QUEUE_COL: assert property (acc_q |=> $stable(rd_col))
    else $error("queue command moved column");
  AST_QUEUE_BUSY: assert property (disable iff (rst || !ce || is_rst)
    acc_q |=> (rb_oe && !unit_ready && !array_ready_bit)[*8]) else $error("queue busy too short");
  AST_EVEN_FIRST: assert property (acc_pg && queued != 2'b00 |=> out_plane == 1'b0 && fetch_go)
    else $error("even plane not selected");
  AST_SELECT: assert property (acc_sel |=> out_plane == $past(a_plane) && rd_col == $past(a_col))
    else $error("select did not redirect output");
  AST_IGNORE_BUSY: assert property (st == NRCS_ST_DBSY && bcnt != 12'h000 && !is_rst |=>
    st == NRCS_ST_DBSY && $stable(queued)) else $error("busy phase disturbed");

  COV_SEQ_IN_CACHE: cover property (cac_st && acc_seq);
  COV_LAST_END: cover property (rc_done && job_last);
  COV_MULTI_PLANE: cover property (acc_pg && queued != 2'b00);

endmodule

// File: verif/nrcs_host_model.sv
// Purpose: Host flash controller model on the sequencer's command side
// Assumes: One logical unit; every strobe is one cycle wide
// Notes:   Idle byte lanes show the inverse of the last byte, never stale data
`timescale 1ns/10ps
module nrcs_host_model (
  input  wire logic       clk,       // Bus clock
  output logic            cmd_we,    // Command strobe
  output logic      [7:0] cmd_byte,  // Command byte
  output logic            addr_we,   // Address strobe
  output logic      [7:0] addr_byte, // Address byte
  output logic            rd_strobe  // Byte read request
);
  initial begin
    cmd_we    = 1'b0;
    cmd_byte  = 8'h5a;
    addr_we   = 1'b0;
    addr_byte = 8'ha5;
    rd_strobe = 1'b0;
  end
  // Command byte: raised just after an edge, dropped after the taking edge
  task automatic put_cmd(input logic [7:0] code);
    @(posedge clk);
    #1;
    cmd_byte = code;
    cmd_we   = 1'b1;
    @(posedge clk);
    #1;
    cmd_we   = 1'b0;
    cmd_byte = ~code;
  endtask
  task automatic put_addr(input logic [7:0] val);
    @(posedge clk);
    #1;
    addr_byte = val;
    addr_we   = 1'b1;
    @(posedge clk);
    #1;
    addr_we   = 1'b0;
    addr_byte = ~val;
  endtask
  task automatic put_row(input logic [7:0] pre, input logic [12:0] col, input logic pl,
                         input logic [6:0] pg, input logic [9:0] blk, input logic [7:0] fin);
    put_cmd(pre);
    put_addr(col[7:0]);
    put_addr({3'h0, col[12:8]});
    put_addr({pl, pg});
    put_addr(blk[7:0]);
    put_addr({6'h00, blk[9:8]});
    put_cmd(fin);
  endtask
  task automatic sel_unit();
    put_cmd(8'h78);
    put_cmd(8'h00);
  endtask
  // unit never walked past its end; bench ends with a reset command
  task automatic read_bytes(input int n);
    repeat (n) begin
      @(posedge clk);
      #1;
      rd_strobe = 1'b1;
      @(posedge clk);
      #1;
      rd_strobe = 1'b0;
    end
  endtask
endmodule

// File: verif/nrcs_sequencer_tb_top.sv
// Purpose: Self-checking bench for the cache read sequencer
// Assumes: Default busy times from the defs header
// Notes:   Cache-busy end waits on the array, so waits are bounded at 3000 cycles
`timescale 1ns/10ps
module nrcs_sequencer_tb_top;
  import nrcs_pkg::*;
  logic              clk, rst, ce, cmd_we, addr_we, rd_strobe, rb_out, rb_oe;
  logic              unit_ready, array_ready_bit, out_plane, fetch_go, fetch_dest, cache_load;
  logic        [7:0] cmd_byte, addr_byte;
  logic       [12:0] rd_col;
  logic        [1:0] fetch_mask;
  logic       [19:0] fetch_block;
  logic       [13:0] fetch_page;
  nrcs_state_t       seq_state;
  int                n_mismatch = 0, n_tests = 0, cyc = 0;
  nrcs_host_model u_host (.clk(clk), .cmd_we(cmd_we), .cmd_byte(cmd_byte), .addr_we(addr_we),
    .addr_byte(addr_byte), .rd_strobe(rd_strobe));
  nrcs_sequencer u_dut (.clk(clk), .rst(rst), .ce(ce), .cmd_we(cmd_we), .cmd_byte(cmd_byte),
    .addr_we(addr_we), .addr_byte(addr_byte), .rd_strobe(rd_strobe), .rb_out(rb_out), .rb_oe(rb_oe),
    .unit_ready(unit_ready), .array_ready_bit(array_ready_bit), .out_plane(out_plane), .rd_col(rd_col),
    .fetch_go(fetch_go), .fetch_dest(fetch_dest), .fetch_mask(fetch_mask), .fetch_block(fetch_block),
    .fetch_page(fetch_page), .cache_load(cache_load), .seq_state(seq_state));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Wait until pin released and unit ready; pulses are seen in that cycle
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (!(unit_ready === 1'b1 && rb_oe === 1'b0) && n < 3000);
    chk(n < 3000, 1'b1);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  task automatic t_page();
    u_host.put_row(8'h00, 13'h0123, 1'b0, 7'h7f, 10'h005, 8'h30);
    chk({fetch_go, fetch_dest, rb_oe}, 3'h7);
    chk(seq_state, NRCS_ST_RBSY);
    wait_ready();
    chk({seq_state, array_ready_bit}, {NRCS_ST_IDLE, 1'b1});
    chk(rd_col, 13'h0123);
    u_host.read_bytes(2);
    chk(rd_col, 13'h0125);
    $display("page read done");
  endtask
  task automatic t_seq();
    u_host.put_cmd(8'h31);
    chk({rb_oe, unit_ready, array_ready_bit}, 3'h4);
    chk(rd_col, 13'h0000);
    u_host.put_cmd(8'h32);
    chk(seq_state, NRCS_ST_RCBSY);
    wait_ready();
    chk({fetch_go, array_ready_bit, seq_state}, {2'b10, NRCS_ST_CACHE});
    chk({fetch_block[9:0], fetch_page[6:0]}, {10'h006, 7'h00});
    $display("sequential done");
  endtask
  task automatic t_rand();
    u_host.sel_unit();
    u_host.put_row(8'h00, 13'h0044, 1'b1, 7'h10, 10'h003, 8'h31);
    chk({rb_oe, unit_ready}, 2'b10);
    wait_ready();
    chk({cache_load, fetch_go, array_ready_bit}, 3'h6);
    chk({fetch_block[19:10], fetch_page[13:7]}, {10'h003, 7'h10});
    chk(rd_col, 13'h0000);
    $display("random done");
  endtask
  task automatic t_end();
    u_host.put_cmd(8'h3f);
    chk({rb_oe, unit_ready, array_ready_bit}, 3'h4);
    wait_ready();
    chk({cache_load, array_ready_bit, seq_state}, {2'b11, NRCS_ST_IDLE});
    chk(rd_col, 13'h0000);
    $display("cache end done");
  endtask
  task automatic t_mplane();
    u_host.put_row(8'h00, 13'h0055, 1'b1, 7'h02, 10'h009, 8'h32);
    chk({rb_oe, unit_ready, array_ready_bit}, 3'h4);
    u_host.put_cmd(8'h31);
    chk(seq_state, NRCS_ST_DBSY);
    wait_ready();
    chk({array_ready_bit, seq_state}, {1'b1, NRCS_ST_MPQ});
    u_host.put_row(8'h00, 13'h0010, 1'b0, 7'h02, 10'h009, 8'h30);
    chk({fetch_go, fetch_dest, fetch_mask}, 4'hf);
    wait_ready();
    chk({out_plane, rd_col}, 14'h0010);
    $display("multi-plane done");
  endtask
  task automatic t_sel();
    u_host.put_row(8'h06, 13'h0020, 1'b1, 7'h02, 10'h009, 8'he0);
    chk({out_plane, rd_col}, {1'b1, 13'h0020});
    u_host.put_cmd(8'h05);
    u_host.put_addr(8'h30);
    u_host.put_addr(8'h00);
    u_host.put_cmd(8'he0);
    chk({out_plane, rd_col}, {1'b1, 13'h0030});
    $display("select done");
  endtask
  task automatic t_mseq();
    u_host.sel_unit();
    u_host.put_cmd(8'h31);
    chk(fetch_page, {7'h03, 7'h03});
    wait_ready();
    chk({fetch_go, fetch_mask}, 3'h7);
    u_host.put_row(8'h00, 13'h0000, 1'b0, 7'h00, 10'h000, 8'h32);
    chk(seq_state, NRCS_ST_CACHE);
    u_host.put_cmd(8'h3f);
    wait_ready();
    chk({cache_load, array_ready_bit, seq_state}, {2'b11, NRCS_ST_IDLE});
    u_host.put_row(8'h00, 13'h0000, 1'b1, 7'h05, 10'h00a, 8'h32);
    u_host.put_cmd(8'hff);
    chk({rb_oe, unit_ready, array_ready_bit, seq_state}, {3'b011, NRCS_ST_IDLE});
    $display("multi-plane sequential done");
  endtask
  initial begin
    rst = 1'b1;
    ce  = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    rst = 1'b0;
    chk({rb_oe, rb_out, unit_ready, array_ready_bit, rd_col}, {4'h3, 13'h0000});
    chk(seq_state, NRCS_ST_IDLE);
    $display("reset done");
    t_page();
    t_seq();
    t_rand();
    t_end();
    t_mplane();
    t_sel();
    t_mseq();
    report_and_stop();
  end
endmodule
